//--- common/bsg_params.svh
/*
 * Constants for the status pin block: pin count, function codes, reset values, timing counts.
 * Assumes a 20 MHz reference clock and inclusion by its bare name.
 */
`ifndef BSG_PARAMS_SVH
`define BSG_PARAMS_SVH
// ************************************************************
// Pin functions
// ************************************************************
`define BSG_NUM_PINS 8
`define BSG_FUNC_W 4
`define BSG_FN_TRISTATE 4'h0
`define BSG_FN_DRIVE1 4'h1
`define BSG_FN_DRIVE0 4'h2
`define BSG_FN_POWER 4'h3
`define BSG_FN_TX_ACTIVITY_LED_N 4'h4
`define BSG_FN_RX_ACTIVITY_LED_N 4'h5
`define BSG_FN_TXRXLED 4'h6
`define BSG_FN_SUSPEND 4'h7
`define BSG_FN_CHG0 4'h8
`define BSG_FN_CHG1 4'h9
`define BSG_FN_VBUS 4'hA
`define BSG_FN_DRVEN 4'hB
// ************************************************************
// Charger codes and timing
// ************************************************************
`define BSG_CHG_NONE_RST 2'h0
`define BSG_CHG_SDP_RST 2'h1
`define BSG_CHG_CDP_DCP_RST 2'h2
`define BSG_CHG_SUSP_RST 2'h3
`define BSG_CLK_HZ 20000000
`define BSG_LED_HOLD_MS 20
`define BSG_LED_HOLD_CYC ((`BSG_CLK_HZ / 1000) * `BSG_LED_HOLD_MS)
`define BSG_DET_CYC 64
`endif

//--- common/bsg_pkg.sv
/*
 * Types shared by the status pin block.
 * Assumes bsg_params.svh is reachable on the include path.
 */
`include "bsg_params.svh"
package bsg_pkg;
  typedef logic [`BSG_FUNC_W-1:0] bsg_func_type;
  typedef enum logic [1:0] {BSG_DET_NONE, BSG_DET_SDP, BSG_DET_CDP, BSG_DET_DCP} bsg_charger_type;
  typedef enum {BSG_ST_IDLE, BSG_ST_DETECT, BSG_ST_DONE} bsg_state_type;
endpackage : bsg_pkg

//--- common/bsg_act_if.sv
/*
 * Carrier between the top module and its activity pulse stretcher.
 * Assumes both ends share ref_clk_i.
 */
`timescale 1ns/1ns
interface bsg_act_if;
  logic tx_evt;
  logic rx_evt;
  logic tx_hold;
  logic rx_hold;
  modport src (output tx_evt, output rx_evt, input tx_hold, input rx_hold);
  modport sink (input tx_evt, input rx_evt, output tx_hold, output rx_hold);
endinterface : bsg_act_if

//--- hw/bsg_act_stretch.sv
/*
 * Stretches one-cycle transfer events into visible LED hold levels.
 * Assumes events are synchronous to ref_clk_i.
 */
`timescale 1ns/1ns
`include "bsg_params.svh"
module bsg_act_stretch #(
  parameter int HOLD_CYC = `BSG_LED_HOLD_CYC
) (
  input wire logic ref_clk_i, // Reference clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  bsg_act_if.sink act // Events in, hold levels out.
);
  import bsg_pkg::*;
  logic [31:0] tx_cnt_q;
  logic [31:0] rx_cnt_q;
  // A fresh event reloads the count, so a steady stream keeps the LED lit.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cnt_q <= 32'h0;
    end else if (act.tx_evt) begin
      tx_cnt_q <= 32'(HOLD_CYC);
    end else if (tx_cnt_q != 32'h0) begin
      tx_cnt_q <= tx_cnt_q - 32'h1;
    end
  end
  // Receive side counts independently.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_cnt_q <= 32'h0;
    end else if (act.rx_evt) begin
      rx_cnt_q <= 32'(HOLD_CYC);
    end else if (rx_cnt_q != 32'h0) begin
      rx_cnt_q <= rx_cnt_q - 32'h1;
    end
  end
  assign act.tx_hold = (tx_cnt_q != 32'h0);
  assign act.rx_hold = (rx_cnt_q != 32'h0);
endmodule : bsg_act_stretch

//--- hw/bsg_status_gpio.sv
/*
 * General pin function mux of the bridge: suspend and power indicators, activity LEDs,
 * line driver enable, ring wake, vbus sense and charger type reporting.
 * Assumes the USB engine supplies same-clock status and the pin function table is static
 * from stored configuration, presented on cfg_func_i and taken once after reset.
 */
`timescale 1ns/1ns
`include "bsg_params.svh"
module bsg_status_gpio #(
  parameter int NPINS = `BSG_NUM_PINS,
  parameter int HOLD_CYC = `BSG_LED_HOLD_CYC,
  parameter int DET_CYC = `BSG_DET_CYC
) (
  input wire logic ref_clk_i, // 20 MHz clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [NPINS*`BSG_FUNC_W-1:0] cfg_func_i, // Stored function per pin.
  input wire logic [7:0] cfg_chg_code_i, // Codes for none, SDP, CDP/DCP, suspend.
  input wire logic usb_suspended_i, // Link suspended.
  input wire logic usb_configured_i, // Device in configured state.
  input wire logic usb_tx_evt_i, // One-cycle USB transmit event.
  input wire logic usb_rx_evt_i, // One-cycle USB receive event.
  input wire logic uart_tx_avail_i, // Character waits in transmit buffer.
  input wire bsg_pkg::bsg_charger_type det_result_i, // Detected charger type.
  input wire logic det_done_i, // Detection result valid.
  input wire logic ring_indicator_n_i, // Ring indicator pin.
  input wire logic [NPINS-1:0] gpio_in_i, // Pin input levels.
  output logic [NPINS-1:0] gpio_out_o, // Pin output levels.
  output logic [NPINS-1:0] gpio_oe_n_o, // Pin enables, low drives.
  output logic det_start_o, // Pulse to start charger detection.
  output logic remote_wake_o, // Pulse requesting wake to host.
  output logic dplus_pullup_o, // D+ pull-up enable.
  output logic vbus_present_o // Sensed vbus level.
);
  import bsg_pkg::*;
  // ************************************************************
  // Configuration capture
  // ************************************************************
  bsg_func_type func_q [NPINS];
  logic loaded_q;
  // Taken once on the first edge after release; later changes need a reset.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
    end
  end
  for (genvar p = 0; p < NPINS; p++) begin : g_cfg
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        func_q[p] <= (p == 4) ? `BSG_FN_SUSPEND : `BSG_FN_TRISTATE;
      end else if (!loaded_q) begin
        func_q[p] <= cfg_func_i[p*`BSG_FUNC_W +: `BSG_FUNC_W];
      end
    end
  end
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NPINS-1:0] pin_m_q, pin_s_q;
  logic ri_m_q, ri_s_q, ri_old_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      ri_m_q <= 1'b1;
      ri_s_q <= 1'b1;
      ri_old_q <= 1'b1;
    end else begin
      pin_m_q <= gpio_in_i;
      pin_s_q <= pin_m_q;
      ri_m_q <= ring_indicator_n_i;
      ri_s_q <= ri_m_q;
      ri_old_q <= ri_s_q;
    end
  end
  // Any pin set to vbus sense contributes; several sense pins are ORed.
  logic vbus_lvl;
  always_comb begin
    vbus_lvl = 1'b0;
    for (int p = 0; p < NPINS; p++) begin
      if (func_q[p] == `BSG_FN_VBUS && pin_s_q[p]) begin
        vbus_lvl = 1'b1;
      end
    end
  end
  // ************************************************************
  // Ring wake
  // ************************************************************
  // Only a falling ring edge during suspend wakes; awake links ignore it.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remote_wake_o <= 1'b0;
    end else begin
      remote_wake_o <= ri_old_q && !ri_s_q && usb_suspended_i;
    end
  end
  // ************************************************************
  // Charger detection
  // ************************************************************
  bsg_state_type st_q;
  logic [15:0] det_cnt_q;
  logic vbus_q;
  bsg_charger_type chg_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vbus_q <= 1'b0;
    end else begin
      vbus_q <= vbus_lvl;
    end
  end
  // Detection runs once per vbus arrival; loss of vbus aborts it at once.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= BSG_ST_IDLE;
      det_start_o <= 1'b0;
      det_cnt_q <= 16'h0;
      chg_q <= BSG_DET_NONE;
      dplus_pullup_o <= 1'b0;
    end else begin
      det_start_o <= 1'b0;
      if (!vbus_lvl) begin
        st_q <= BSG_ST_IDLE;
        chg_q <= BSG_DET_NONE;
        dplus_pullup_o <= 1'b0;
      end else begin
        case (st_q)
          BSG_ST_IDLE: begin
            if (!vbus_q) begin
              st_q <= BSG_ST_DETECT;
              det_start_o <= 1'b1;
              det_cnt_q <= 16'(DET_CYC);
            end
          end
          BSG_ST_DETECT: begin
            if (det_cnt_q != 16'h0) begin
              det_cnt_q <= det_cnt_q - 16'h1;
            end
            if (det_done_i) begin
              st_q <= BSG_ST_DONE;
              chg_q <= det_result_i;
              dplus_pullup_o <= (det_result_i == BSG_DET_SDP) || (det_result_i == BSG_DET_CDP);
            end else if (det_cnt_q == 16'h0) begin
              // No answer in time is treated as a standard port.
              st_q <= BSG_ST_DONE;
              chg_q <= BSG_DET_SDP;
              dplus_pullup_o <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Code shown on the charger-type pins; suspend overrides any port type.
  logic [1:0] chg_code;
  always_comb begin
    if (!vbus_q || chg_q == BSG_DET_NONE) begin
      chg_code = cfg_chg_code_i[1:0];
    end else if (usb_suspended_i) begin
      chg_code = cfg_chg_code_i[7:6];
    end else if (chg_q == BSG_DET_SDP) begin
      chg_code = cfg_chg_code_i[3:2];
    end else begin
      chg_code = cfg_chg_code_i[5:4];
    end
  end
  // ************************************************************
  // Activity stretching
  // ************************************************************
  bsg_act_if act ();
  assign act.tx_evt = usb_tx_evt_i;
  assign act.rx_evt = usb_rx_evt_i;
  bsg_act_stretch #(.HOLD_CYC(HOLD_CYC)) u_stretch (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .act(act)
  );
  // ************************************************************
  // Pin output mux
  // ************************************************************
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        gpio_out_o[p] <= 1'b1;
        gpio_oe_n_o[p] <= 1'b1;
      end else begin
        gpio_oe_n_o[p] <= 1'b0;
        case (func_q[p])
          `BSG_FN_DRIVE1: gpio_out_o[p] <= 1'b1;
          `BSG_FN_DRIVE0: gpio_out_o[p] <= 1'b0;
          `BSG_FN_POWER: gpio_out_o[p] <= !(usb_configured_i && !usb_suspended_i);
          `BSG_FN_SUSPEND: gpio_out_o[p] <= !usb_suspended_i;
          `BSG_FN_TX_ACTIVITY_LED_N: gpio_out_o[p] <= !act.tx_hold;
          `BSG_FN_RX_ACTIVITY_LED_N: gpio_out_o[p] <= !act.rx_hold;
          `BSG_FN_TXRXLED: gpio_out_o[p] <= !(act.tx_hold || act.rx_hold);
          `BSG_FN_CHG0: gpio_out_o[p] <= chg_code[0];
          `BSG_FN_CHG1: gpio_out_o[p] <= chg_code[1];
          `BSG_FN_DRVEN: gpio_out_o[p] <= uart_tx_avail_i;
          default: begin
            gpio_out_o[p] <= 1'b1;
            gpio_oe_n_o[p] <= 1'b1;
          end
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vbus_present_o <= 1'b0;
    end else begin
      vbus_present_o <= vbus_q;
    end
  end
  // ************************************************************
  // Checks
  // ************************************************************
  chk_susp_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (loaded_q && func_q[4] == `BSG_FN_SUSPEND) |=> (gpio_out_o[4] == !$past(usb_suspended_i)))
    else $error("suspend indicator wrong");
  chk_power_low: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (func_q[4] == `BSG_FN_POWER && (!usb_configured_i || usb_suspended_i)) |=> gpio_out_o[4])
    else $error("power control low while unconfigured");
  chk_drven_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (func_q[3] == `BSG_FN_DRVEN && loaded_q) |=> (gpio_out_o[3] == $past(uart_tx_avail_i)))
    else $error("driver enable mismatch");
  chk_vbus_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_q == BSG_ST_IDLE && vbus_lvl && !vbus_q) |=> det_start_o)
    else $error("detection not started");
  chk_pullup_drop: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !vbus_lvl |=> (!dplus_pullup_o && chg_q == BSG_DET_NONE))
    else $error("pullup kept without vbus");
  chk_pullup_type: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_q == BSG_ST_DETECT && vbus_lvl && det_done_i && det_result_i == BSG_DET_DCP) |=> !dplus_pullup_o)
    else $error("pullup on dedicated charger");
  chk_wake_susp: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    remote_wake_o |-> $past(usb_suspended_i))
    else $error("wake outside suspend");
  chk_led_event: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (usb_tx_evt_i && func_q[0] == `BSG_FN_TX_ACTIVITY_LED_N) |=> ##1 !gpio_out_o[0])
    else $error("tx LED not lit");
  chk_cfg_static: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    loaded_q |=> $stable(func_q[4]))
    else $error("pin function changed");
  cov_wake: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) remote_wake_o);
  cov_sdp: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) st_q == BSG_ST_DONE && dplus_pullup_o);
  cov_led: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) act.tx_hold && act.rx_hold);
endmodule : bsg_status_gpio

//--- sim/bsg_board_model.sv
/*
 * Board around the status pins: pin level resolution, the vbus divider and the ring line.
 * Assumes eight pins and a low-active output enable from the device.
 */
`timescale 1ns/1ns
module bsg_board_model (
  input wire logic ref_clk_i, // Clock for the float pattern.
  input wire logic [7:0] gpio_out_i, // Device pin levels.
  input wire logic [7:0] gpio_oe_n_i, // Device enables, low drives.
  input wire logic vbus_on_i, // Cable attached.
  input wire logic ring_req_i, // Attached party asks for wake.
  output logic [7:0] gpio_in_o, // Resolved pin levels.
  output logic ring_indicator_n_o // Ring line with pull-up.
);
  logic flt_q = 1'b0;
  // A floating pin toggles every cycle so no settled guess can hide a missing drive.
  always_ff @(posedge ref_clk_i) begin
    flt_q <= ~flt_q;
  end
  // Pins show the device level while driven; the vbus pin sees the cable through its pull-down.
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      gpio_in_o[p] = gpio_oe_n_i[p] ? flt_q : gpio_out_i[p];
    end
    if (gpio_oe_n_i[7]) begin
      gpio_in_o[7] = vbus_on_i;
    end
  end
  // The ring line idles high and is pulled low on request.
  assign ring_indicator_n_o = ~ring_req_i;
endmodule : bsg_board_model

//--- sim/testbench.sv
/*
 * Self-checking bench for the status pin block with a board model on its pins.
 * Assumes the short hold and detection counts set below.
 */
`timescale 1ns/1ns
module testbench;
  import bsg_pkg::*;
  localparam int HOLD = 4;
  localparam int DET = 8;
  logic ref_clk_i, rstn_i, usb_suspended_i, usb_configured_i, usb_tx_evt_i, usb_rx_evt_i;
  logic uart_tx_avail_i, det_done_i, ring_indicator_n_i, vbus_on, ring_req;
  logic det_start_o, remote_wake_o, dplus_pullup_o, vbus_present_o;
  logic [31:0] cfg_func_i;
  logic [7:0] cfg_chg_code_i, gpio_in_i, gpio_out_o, gpio_oe_n_o;
  bsg_charger_type det_result_i;
  int seed, miscompares, compares, n;
  // ************************************************************
  // Design and board
  // ************************************************************
  bsg_status_gpio #(.NPINS(8), .HOLD_CYC(HOLD), .DET_CYC(DET)) i_dut (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .cfg_func_i(cfg_func_i), .cfg_chg_code_i(cfg_chg_code_i),
    .usb_suspended_i(usb_suspended_i), .usb_configured_i(usb_configured_i),
    .usb_tx_evt_i(usb_tx_evt_i), .usb_rx_evt_i(usb_rx_evt_i), .uart_tx_avail_i(uart_tx_avail_i),
    .det_result_i(det_result_i), .det_done_i(det_done_i), .ring_indicator_n_i(ring_indicator_n_i),
    .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o), .gpio_oe_n_o(gpio_oe_n_o),
    .det_start_o(det_start_o), .remote_wake_o(remote_wake_o), .dplus_pullup_o(dplus_pullup_o),
    .vbus_present_o(vbus_present_o));
  bsg_board_model i_board (.ref_clk_i(ref_clk_i), .gpio_out_i(gpio_out_o), .gpio_oe_n_i(gpio_oe_n_o),
    .vbus_on_i(vbus_on), .ring_req_i(ring_req), .gpio_in_o(gpio_in_i),
    .ring_indicator_n_o(ring_indicator_n_i));
  // Free-running 20 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  // Waits k rising edges and lands on the following falling edge, where outputs are settled.
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : cyc
  // Reset with a new pin table; the table is held steady over the capture edge.
  task automatic do_reset(input logic [31:0] cfg);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    cfg_func_i <= cfg;
    cyc(1);
    check(gpio_oe_n_o, 8'hFF);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    cyc(4);
  endtask : do_reset
  // Code pins follow the SDP slot for SDP or a timeout, otherwise the CDP/DCP slot.
  function automatic logic [1:0] exp_code(input int k, input logic [7:0] c);
    return (k == 1 || k == 4) ? c[3:2] : c[5:4];
  endfunction : exp_code
  function automatic logic exp_pull(input int k);
    return k != 3;
  endfunction : exp_pull
  // Walks every suspend and configured combination on pin four.
  task automatic run_sp(input logic pwr);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      usb_suspended_i <= i[0];
      usb_configured_i <= i[1];
      cyc(3);
      check({7'h00, gpio_oe_n_o[4]}, 8'h00);
      if (pwr) check({7'h00, gpio_out_o[4]}, {7'h00, ~(i[1] & ~i[0])});
      else check({7'h00, gpio_out_o[4]}, {7'h00, ~i[0]});
    end
    // Leave the link awake so later code pin checks see the port type slot.
    @(posedge ref_clk_i);
    usb_suspended_i <= 1'b0;
    $display("Pin four test done");
  endtask : run_sp
  // Counts wake pulses over a fixed window after the ring line falls.
  task automatic ring_try(input logic susp, input logic [7:0] exp);
    int cnt;
    cnt = 0;
    @(posedge ref_clk_i);
    usb_suspended_i <= susp;
    ring_req <= 1'b1;
    repeat (10) begin
      @(negedge ref_clk_i);
      if (remote_wake_o === 1'b1) cnt++;
    end
    check(cnt[7:0], exp);
    @(posedge ref_clk_i);
    ring_req <= 1'b0;
    cyc(4);
  endtask : ring_try
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 84010;
    {rstn_i, usb_suspended_i, usb_configured_i, usb_tx_evt_i, usb_rx_evt_i} = 5'h00;
    {uart_tx_avail_i, det_done_i, vbus_on, ring_req} = 4'h0;
    cfg_func_i = 32'hA987B654;
    cfg_chg_code_i = 8'hE4;
    det_result_i = BSG_DET_NONE;
    do_reset(32'hA987B654);
    run_sp(1'b0);
    // Driver enable follows a waiting character, drawn at random.
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk_i);
      uart_tx_avail_i <= $random(seed);
      cyc(3);
      check({7'h00, gpio_out_o[3]}, {7'h00, uart_tx_avail_i});
    end
    $display("Driver enable test done");
    // Transmit, receive, then both at once; pins 2..0 are combined, receive, transmit, active low.
    for (int d = 0; d < 3; d++) begin
      @(posedge ref_clk_i);
      usb_tx_evt_i <= (d != 1);
      usb_rx_evt_i <= (d != 0);
      @(posedge ref_clk_i);
      {usb_tx_evt_i, usb_rx_evt_i} <= 2'h0;
      cyc(2);
      check({5'h00, gpio_out_o[2:0]}, (d == 0) ? 8'h02 : (d == 1) ? 8'h01 : 8'h00);
      cyc(HOLD + 6);
      check({5'h00, gpio_out_o[2:0]}, 8'h07);
    end
    $display("LED test done");
    // Attach, detect each charger kind or time out, then detach.
    for (int k = 1; k < 5; k++) begin
      @(posedge ref_clk_i);
      cfg_chg_code_i <= $random(seed);
      vbus_on <= 1'b1;
      for (n = 0; n < 20 && det_start_o !== 1'b1; n++) @(negedge ref_clk_i);
      if (n == 20) begin
        miscompares++;
        finish_test();
      end
      if (k < 4) begin
        @(posedge ref_clk_i);
        det_result_i <= bsg_charger_type'(k[1:0]);
        det_done_i <= 1'b1;
        @(posedge ref_clk_i);
        det_done_i <= 1'b0;
      end
      cyc(DET + 4);
      check({7'h00, vbus_present_o}, 8'h01);
      check({7'h00, dplus_pullup_o}, {7'h00, exp_pull(k)});
      check({6'h00, gpio_out_o[6:5]}, {6'h00, exp_code(k, cfg_chg_code_i)});
      // Suspend overrides the port type while vbus stays present.
      @(posedge ref_clk_i);
      usb_suspended_i <= 1'b1;
      cyc(2);
      check({6'h00, gpio_out_o[6:5]}, {6'h00, cfg_chg_code_i[7:6]});
      @(posedge ref_clk_i);
      usb_suspended_i <= 1'b0;
      @(posedge ref_clk_i);
      vbus_on <= 1'b0;
      cyc(6);
      check({7'h00, dplus_pullup_o}, 8'h00);
      check({7'h00, vbus_present_o}, 8'h00);
      check({6'h00, gpio_out_o[6:5]}, {6'h00, cfg_chg_code_i[1:0]});
    end
    $display("Charger test done");
    ring_try(1'b1, 8'h01);
    ring_try(1'b0, 8'h00);
    $display("Ring test done");
    do_reset(32'hA983B654);
    run_sp(1'b1);
    // Tristate, static levels and a refused code; a later table change must not take.
    do_reset(32'h0000F210);
    for (int r = 0; r < 2; r++) begin
      check({4'h0, gpio_oe_n_o[3:0]}, 8'h09);
      check({6'h00, gpio_out_o[2:1]}, 8'h01);
      @(posedge ref_clk_i);
      cfg_func_i <= 32'h44444444;
      cyc(4);
    end
    $display("Static pin test done");
    finish_test();
  end
endmodule : testbench
